// File: verilog/fpr_router.v
/*
 Fiber port configuration router: captures option switches after
 reset, routes serial data between the copper side and fiber ports A
 and B, handles idle polarity and redundancy failover.
 Assumes all inputs synchronous to clk; srst acts as power-on reset.
*/
`timescale 1ns/1ps
`include "fpr_map.vh"
module fpr_router (
   clk,
   srst,
   clk_en,
   two_port_variant,
   topology_select_switch,
   idle_polarity_switch,
   redundancy_enable_switch,
   second_port_disable_switch,
   serial_rx,
   fiber_a_rx,
   fiber_b_rx,
   fiber_a_level,
   fiber_b_level,
   serial_tx,
   fiber_a_tx,
   fiber_b_tx,
   bar_graph_a,
   bar_graph_b,
   error_led_a,
   error_led_b,
   star_mode,
   normal_idle_polarity,
   redundancy_mode,
   port_b_active,
   active_on_b
);
   input                   clk;
   input                   srst;
   input                   clk_en;
   input                   two_port_variant;
   input                   topology_select_switch;
   input                   idle_polarity_switch;
   input                   redundancy_enable_switch;
   input                   second_port_disable_switch;
   input                   serial_rx;
   input                   fiber_a_rx;
   input                   fiber_b_rx;
   input  [`FPR_LVL_W-1:0] fiber_a_level;
   input  [`FPR_LVL_W-1:0] fiber_b_level;
   output                  serial_tx;
   output                  fiber_a_tx;
   output                  fiber_b_tx;
   output [`FPR_BAR_W-1:0] bar_graph_a;
   output [`FPR_BAR_W-1:0] bar_graph_b;
   output                  error_led_a;
   output                  error_led_b;
   output                  star_mode;
   output                  normal_idle_polarity;
   output                  redundancy_mode;
   output                  port_b_active;
   output                  active_on_b;

   reg                     serial_tx;
   reg                     fiber_a_tx;
   reg                     fiber_b_tx;
   reg                     star_mode;
   reg                     normal_idle_polarity;
   reg                     redundancy_mode;
   reg                     port_b_active;
   reg                     active_on_b;
   reg                     captured;
   reg                     next_serial_tx;
   reg                     line_a_tx;
   reg                     line_b_tx;
   wire                    a_log;
   wire                    b_log;
   wire                    inverted_idle_polarity;

   // -----------------------------------------------------------------
   // Configuration capture
   // -----------------------------------------------------------------
   // capture once after reset
   always @(posedge clk) begin
      if (srst) begin
         captured             <= 1'b0;
         star_mode            <= `FPR_TOPO_RST;
         normal_idle_polarity <= `FPR_POL_RST;
         redundancy_mode      <= `FPR_RED_RST;
         port_b_active        <= 1'b0;
      end else if (clk_en && !captured) begin
         captured             <= 1'b1;
         star_mode            <= topology_select_switch;
         redundancy_mode      <= two_port_variant && redundancy_enable_switch;
         normal_idle_polarity <= idle_polarity_switch &&
                                 !(two_port_variant && redundancy_enable_switch);
         port_b_active        <= two_port_variant && !second_port_disable_switch;
      end
   end

   // -----------------------------------------------------------------
   // Idle polarity
   // -----------------------------------------------------------------
   // Inverted idle keeps light on between characters for diagnostics
   assign inverted_idle_polarity = !normal_idle_polarity;

   // -----------------------------------------------------------------
   // Failover
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         active_on_b <= 1'b0;
      end else if (clk_en) begin
         // switch to B at critical or error level
         // Sticky until reset so a marginal port A cannot flap the path
         // A disabled port B leaves the path on A
         if (redundancy_mode && port_b_active &&
             fiber_a_level <= `FPR_LVL_CRIT) begin
            active_on_b <= 1'b1;
         end else if (!redundancy_mode) begin
            active_on_b <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Receive decode (light on = 1 when inverted polarity)
   // -----------------------------------------------------------------
   // A disabled port B reads as idle high
   assign a_log = inverted_idle_polarity ? fiber_a_rx : !fiber_a_rx;
   assign b_log = port_b_active ? (inverted_idle_polarity ? fiber_b_rx : !fiber_b_rx) : 1'b1;

   // -----------------------------------------------------------------
   // Data routing
   // -----------------------------------------------------------------

   always @* begin
      line_a_tx      = serial_rx;
      line_b_tx      = 1'b1;
      next_serial_tx = 1'b1;
      if (redundancy_mode) begin
         next_serial_tx = active_on_b ? b_log : a_log;
         line_a_tx      = serial_rx;
         line_b_tx      = serial_rx;
      end else if (star_mode) begin
         next_serial_tx = a_log & b_log;
         line_a_tx      = serial_rx;
         line_b_tx      = serial_rx;
      end else begin
         next_serial_tx = a_log;
         // Serial and B merge by AND, both idle high
         line_a_tx      = serial_rx & b_log;
         line_b_tx      = a_log;
      end
   end

   // -----------------------------------------------------------------
   // Transmit registers
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         serial_tx  <= 1'b1;
         fiber_a_tx <= 1'b1;
         fiber_b_tx <= 1'b0;
      end else if (clk_en) begin
         serial_tx  <= next_serial_tx;
         fiber_a_tx <= inverted_idle_polarity ? line_a_tx : !line_a_tx;
         fiber_b_tx <= port_b_active &&
                       (inverted_idle_polarity ? line_b_tx : !line_b_tx);
      end
   end

   // -----------------------------------------------------------------
   // Diagnostics
   // -----------------------------------------------------------------
   // Port A counts as active once the settings are captured
   fpr_port_diag u_diag_a (
      .clk                     (clk),
      .srst                    (srst),
      .clk_en                  (clk_en),
      .port_active             (captured),
      .diag_enable             (inverted_idle_polarity),
      .rx_level                (fiber_a_level),
      .optical_level_bar_graph (bar_graph_a),
      .error_led               (error_led_a)
   );

   fpr_port_diag u_diag_b (
      .clk                     (clk),
      .srst                    (srst),
      .clk_en                  (clk_en),
      .port_active             (port_b_active),
      .diag_enable             (inverted_idle_polarity),
      .rx_level                (fiber_b_level),
      .optical_level_bar_graph (bar_graph_b),
      .error_led               (error_led_b)
   );
endmodule // fpr_router

// File: common/fpr_map.vh
/*
 Constants for the fiber port configuration router.
 Assumes a single 20 MHz system clock.
*/
`ifndef FPR_MAP_VH
`define FPR_MAP_VH
// -----------------------------------------------------------------
// Switch reset values (all off by default)
// -----------------------------------------------------------------
`define FPR_TOPO_RST      1'b0
`define FPR_POL_RST       1'b0
`define FPR_RED_RST       1'b0
`define FPR_BDIS_RST      1'b0
// -----------------------------------------------------------------
// Optical level codes
// -----------------------------------------------------------------
`define FPR_LVL_W         2
`define FPR_LVL_ERROR     2'h0
`define FPR_LVL_CRIT      2'h1
`define FPR_LVL_GOOD      2'h2
`define FPR_LVL_VGOOD     2'h3
// -----------------------------------------------------------------
// Bar graph: bit 0 yellow, bit 1 lower green, bit 2 upper green
// -----------------------------------------------------------------
`define FPR_BAR_W         3
`define FPR_BAR_OFF       3'h0
`define FPR_BAR_CRIT      3'h1
`define FPR_BAR_GOOD      3'h3
`define FPR_BAR_VGOOD     3'h7
`endif

// File: verilog/fpr_port_diag.v
/*
 Per-port optical diagnostics: bar graph and error lamp.
 Assumes the level code is synchronous to clk.
*/
`timescale 1ns/1ps
`include "fpr_map.vh"
module fpr_port_diag (
   clk,
   srst,
   clk_en,
   port_active,
   diag_enable,
   rx_level,
   optical_level_bar_graph,
   error_led
);
   input                   clk;
   input                   srst;
   input                   clk_en;
   input                   port_active;
   input                   diag_enable;
   input  [`FPR_LVL_W-1:0] rx_level;
   output [`FPR_BAR_W-1:0] optical_level_bar_graph;
   output                  error_led;

   reg    [`FPR_BAR_W-1:0] optical_level_bar_graph;
   reg                     error_led;
   reg    [`FPR_BAR_W-1:0] next_bar;

   always @* begin
      next_bar = `FPR_BAR_OFF;
      case (rx_level)
         `FPR_LVL_VGOOD: next_bar = `FPR_BAR_VGOOD;
         `FPR_LVL_GOOD:  next_bar = `FPR_BAR_GOOD;
         `FPR_LVL_CRIT:  next_bar = `FPR_BAR_CRIT;
         default:        next_bar = `FPR_BAR_OFF;
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         optical_level_bar_graph <= `FPR_BAR_OFF;
         error_led               <= 1'b0;
      end else if (clk_en) begin
         optical_level_bar_graph <= (port_active && diag_enable) ? next_bar : `FPR_BAR_OFF;
         error_led               <= port_active && (rx_level == `FPR_LVL_ERROR);
      end
   end
endmodule // fpr_port_diag

// File: verification/fpr_peer.sv
/* Peer fiber converter: turns logic bits and levels into received light.
   Assumes the bench sets its inputs at clock edges. */
`timescale 1ns/1ps
module fpr_peer (
   input  wire logic       pol,
   input  wire logic       a_bit,
   input  wire logic       b_bit,
   input  wire logic [1:0] a_lvl,
   input  wire logic [1:0] b_lvl,
   output wire logic       a_rx,
   output wire logic       b_rx
);
   // peer keeps the same polarity as the router
   // A to A, B to B; no light without signal
   assign a_rx = (a_lvl != 2'h0) & (a_bit ^ pol);
   assign b_rx = (b_lvl != 2'h0) & (b_bit ^ pol);
endmodule // fpr_peer

// File: verification/fpr_router_assertions.sv
/* Port checker for fpr_router.
   Assumes clk_en may be held low for a while. */
`timescale 1ns/1ps
module fpr_router_assertions (
   input wire logic       clk, srst, clk_en, two_port_variant, serial_rx, fiber_a_rx,
   input wire logic [1:0] fiber_a_level, fiber_b_level,
   input wire logic       fiber_a_tx, fiber_b_tx, error_led_b, active_on_b, star_mode,
   input wire logic [2:0] bar_graph_a, bar_graph_b,
   input wire logic       normal_idle_polarity, redundancy_mode, port_b_active
);
   logic up;
   logic old;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Up: settings captured; old: captured one edge earlier
   always @(posedge clk) begin
      up  <= srst ? 1'b0 : (up | clk_en);
      old <= srst ? 1'b0 : up;
   end
   cfg_hold_a:
      assert property (old |-> $stable({star_mode, normal_idle_polarity, redundancy_mode,
         port_b_active})) else $error("settings moved");
   redund_pol_a:
      assert property (redundancy_mode |-> !normal_idle_polarity) else $error("polarity");
   b_off_a:
      assert property (!port_b_active |-> !fiber_b_tx && bar_graph_b == 3'h0)
         else $error("port b not off");
   diag_hide_a:
      assert property (old && normal_idle_polarity |-> bar_graph_a == 3'h0
         && bar_graph_b == 3'h0) else $error("bar lit");
   star_tx_a:
      assert property (old && $past(clk_en) && (star_mode || redundancy_mode) |->
         fiber_a_tx == ($past(serial_rx) ^ normal_idle_polarity)) else $error("a tx");
   line_b_a:
      assert property (old && $past(clk_en) && !star_mode && !redundancy_mode
         && port_b_active |-> fiber_b_tx == $past(fiber_a_rx)) else $error("b tx");
   fail_set_a:
      assert property (clk_en && up && redundancy_mode && port_b_active
         && fiber_a_level <= 2'h1 |=> active_on_b) else $error("no failover");
   fail_cause_a:
      assert property ($rose(active_on_b) |-> $past(clk_en && redundancy_mode && port_b_active
         && fiber_a_level <= 2'h1)) else $error("early failover");
   fail_stay_a:
      assert property (active_on_b |=> active_on_b) else $error("failback");
   err_b_a:
      assert property (old && $past(clk_en) |-> error_led_b == $past(port_b_active
         && fiber_b_level == 2'h0)) else $error("err b");
   term_a:
      assert property (up && !two_port_variant |-> !port_b_active && !redundancy_mode)
         else $error("terminal");
endmodule // fpr_router_assertions
bind fpr_router fpr_router_assertions fpr_router_assertions_inst (.clk, .srst, .clk_en,
   .two_port_variant, .serial_rx, .fiber_a_rx, .fiber_a_level, .fiber_b_level, .fiber_a_tx,
   .fiber_b_tx, .error_led_b, .active_on_b, .star_mode, .bar_graph_a, .bar_graph_b,
   .normal_idle_polarity, .redundancy_mode, .port_b_active);

// File: verification/fpr_router_tb.sv
/* Self-checking bench for fpr_router with a peer converter model.
   Assumes settings are captured at the first enabled edge after reset. */
`timescale 1ns/1ps
`include "fpr_map.vh"
module fpr_router_tb;
   logic       clk = 1'b0, srst = 1'b1, tpv = 1'b1, s_rx = 1'b1, pol = 1'b0, ce = 1'b1;
   logic       a_bit = 1'b1, b_bit = 1'b1, a_rx, b_rx, s_tx, a_tx, b_tx, err_a, err_b;
   logic       star, nrm, red, bact, aob, e_star, e_nrm, e_red, e_bact, e_aob;
   logic [3:0] sw = 4'h0;
   logic [1:0] a_lvl = 2'h3, b_lvl = 2'h3;
   logic [2:0] bar_a, bar_b;
   int         failures = 0, n_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   fpr_router fpr_router_inst (.clk(clk), .srst(srst), .clk_en(ce), .two_port_variant(tpv),
      .topology_select_switch(sw[0]), .idle_polarity_switch(sw[1]),
      .redundancy_enable_switch(sw[2]), .second_port_disable_switch(sw[3]),
      .serial_rx(s_rx), .fiber_a_rx(a_rx), .fiber_b_rx(b_rx), .fiber_a_level(a_lvl),
      .fiber_b_level(b_lvl), .serial_tx(s_tx), .fiber_a_tx(a_tx), .fiber_b_tx(b_tx),
      .bar_graph_a(bar_a), .bar_graph_b(bar_b), .error_led_a(err_a), .error_led_b(err_b),
      .star_mode(star), .normal_idle_polarity(nrm), .redundancy_mode(red),
      .port_b_active(bact), .active_on_b(aob));
   fpr_peer fpr_peer_inst (.pol(pol), .a_bit(a_bit), .b_bit(b_bit), .a_lvl(a_lvl),
      .b_lvl(b_lvl), .a_rx(a_rx), .b_rx(b_rx));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic boot(input logic t, input logic [3:0] s);
      @(posedge clk);
      srst <= 1'b1;
      tpv <= t;
      sw <= s;
      {e_star, e_red, e_bact, e_aob} = {s[0], t & s[2], t & ~s[3], 1'b0};
      e_nrm = s[1] & ~e_red;
      pol <= e_nrm;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({star, nrm, red}, 3'h0);
      chk({1'b0, bact, aob}, 3'h0);
      chk(bar_a, `FPR_BAR_OFF);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      sw <= ~s;
      repeat (2) @(posedge clk);
      #1;
      chk(star, e_star);
      chk(nrm, e_nrm);
      chk(red, e_red);
      chk(bact, e_bact);
      chk({star, red, bact}, {e_star, e_red, e_bact});
   endtask
   task automatic drive(input logic s, input logic a, input logic b);
      logic       bl;
      logic [2:0] exp;
      @(posedge clk);
      s_rx <= s;
      a_bit <= a;
      b_bit <= b;
      // three-cycle bits, far above 9.6 kbps
      repeat (2) @(posedge clk);
      #1;
      bl = e_bact ? b : 1'b1;
      if (e_red) exp = {e_aob ? b : a, s, s};
      else if (e_star) exp = {a & bl, s, s};
      else exp = {a, s & bl, a};
      chk(s_tx, exp[2]);
      chk(a_tx, exp[1] ^ e_nrm);
      chk(b_tx, e_bact & (exp[0] ^ e_nrm));
   endtask
   task automatic levels();
      logic [2:0] map [4] = '{`FPR_BAR_OFF, `FPR_BAR_CRIT, `FPR_BAR_GOOD, `FPR_BAR_VGOOD};
      for (int i = 3; i >= 0; i--) begin
         @(posedge clk);
         a_lvl <= i[1:0];
         b_lvl <= i[1:0];
         repeat (2) @(posedge clk);
         #1;
         e_aob = e_aob | (e_red & e_bact & (i <= 1));
         chk(bar_a, e_nrm ? 3'h0 : map[i]);
         chk(bar_b, (e_nrm | ~e_bact) ? 3'h0 : map[i]);
         chk(err_a, i == 0);
         chk(err_b, e_bact & (i == 0));
         chk(aob, e_aob);
      end
      a_lvl <= 2'h3;
      b_lvl <= 2'h3;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      for (int k = 0; k < 20; k++) begin
         boot(k < 16, k < 16 ? k[3:0] : k[3:0] | 4'hc);
         for (int d = 0; d < 8; d++) drive(d[2], d[1], d[0]);
         levels();
         for (int d = 0; d < 8; d++) drive(d[2], d[1], d[0]);
      end
      conclude();
   end
endmodule // fpr_router_tb
